// File: design/interval_stop_arming_holdoff.sv
// Interval measurement control with start arming, stop hold-off and pacing, APB slave.
// Assumes inputs A, B, C, E are asynchronous pins; one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "arming_cfg.svh"
module interval_stop_arming_holdoff #(
   parameter int DEPTH = 64
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire arming_pkg::inputs_t   pins,
   output logic                       go_detect_bypass,
   output logic                       averaging_on,
   output logic                       meas_busy
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [31:0] MIN_DLY = 32'(`MIN_DELAY_CYC);

   // Two flip-flop synchronisers for the pins
   // The third stage only keeps the last synchronised level for edge detection
   arming_pkg::inputs_t s1, s2, s3, next_s1, next_s2, next_s3;
   always_comb begin
      next_s1 = pins;
      next_s2 = s1;
      next_s3 = s2;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= next_s1;
         s2 <= next_s2;
         s3 <= next_s3;
      end
   end

   // Registers
   arming_pkg::ctrl_t ctrl, next_ctrl;
   logic [31:0] holdoff_time, next_holdoff_time;
   logic [23:0] holdoff_evt, next_holdoff_evt;
   logic [31:0] start_delay, next_start_delay;
   logic [23:0] stop_evt, next_stop_evt;
   logic [31:0] result, next_result;
   logic [31:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [AW:0]   fill, next_fill;
   logic          done_flag, next_done_flag;

   // Edge detection on synchronised levels only
   logic b_src, b_prev, next_b_prev;
   logic a_rise, b_rise, e_rise, e_fall, c_rise, start_src;
   assign b_src  = ctrl.common_input_routing ? s2.in_a : s2.in_b;
   always_comb next_b_prev = b_src;
   assign a_rise = s2.in_a & ~s3.in_a;
   assign c_rise = s2.in_c & ~s3.in_c;
   assign b_rise = b_src & ~b_prev;
   assign e_rise = s2.in_e & ~s3.in_e;
   assign e_fall = ~s2.in_e & s3.in_e;
   assign start_src = ctrl.use_c ? c_rise : a_rise;

   assign go_detect_bypass = ctrl.start_arm;
   assign averaging_on     = ~ctrl.single;

   // Measurement machine
   arming_pkg::meas_state_t state, next_state;
   logic [31:0] tcnt, next_tcnt;
   logic [31:0] dcnt, next_dcnt;
   logic [23:0] ecnt, next_ecnt;
   logic [23:0] scnt, next_scnt;
   logic        ext_ok, next_ext_ok;
   logic        hold_time_en, hold_evt_en, stop_evt_en, stop_ok;
   logic        arm_edge;
   logic [31:0] pace_cyc, dly_eff;

   // Counted hold-off is refused while time-delayed start arming is on
   assign hold_evt_en  = ctrl.holdoff_on & ctrl.holdoff_by_events
                         & ~ctrl.start_delay_on;
   assign hold_time_en = ctrl.holdoff_on & ~ctrl.holdoff_by_events;
   assign stop_evt_en  = (stop_evt >= `EVT_MIN);
   assign arm_edge     = ctrl.arm_from_b ? b_rise : e_rise;
   assign dly_eff      = (start_delay < MIN_DLY) ? MIN_DLY : start_delay;
   assign pace_cyc     = ctrl.fast_model ? 32'(`PACE_FAST_CYC)
                                         : 32'(`PACE_SLOW_CYC);
   // Every enabled inhibit must have run out before a stop is taken
   assign stop_ok = (!hold_time_en || tcnt == 32'h00000000)
                  && (!hold_evt_en || ecnt == 24'h000000)
                  && (!stop_evt_en || scnt == 24'h000000)
                  && (!ctrl.stop_arm_trailing || ext_ok);
   assign meas_busy = state == arming_pkg::st_run;

   logic store;
   always_comb begin
      next_state  = state;
      next_tcnt   = tcnt;
      next_dcnt   = dcnt;
      next_ecnt   = ecnt;
      next_scnt   = scnt;
      next_ext_ok = ext_ok;
      next_result = result;
      store       = 1'b0;
      case (state)
         arming_pkg::st_idle: begin
            // Start delay reloads on every arming, so each shot waits the full time
            if (ctrl.enable) begin
               next_dcnt  = dly_eff;
               next_state = arming_pkg::st_armed;
            end
         end
         arming_pkg::st_armed: begin
            if (!ctrl.enable) begin
               next_state = arming_pkg::st_idle;
            end else if (ctrl.start_arm && !ctrl.start_delay_on) begin
               // Wait for the arming edge, then the first trigger starts
               if (arm_edge) begin
                  next_state = arming_pkg::st_armed;
                  next_dcnt  = 32'h00000000;
               end
            end
            if (ctrl.start_arm && ctrl.start_delay_on && dcnt != 32'h00000000
                && (dcnt != dly_eff || arm_edge)) begin
               next_dcnt = dcnt - 32'h00000001;
            end
            // Start on first trigger once armed; burst start sets time zero
            if (ctrl.enable && start_src && (!ctrl.start_arm || dcnt == 32'h00000000)) begin
               next_state  = arming_pkg::st_run;
               next_tcnt   = holdoff_time;
               // With common routing the start pulse is also the first stop-channel event
               next_ecnt   = (b_rise && holdoff_evt != 24'h000000)
                             ? holdoff_evt - 24'h000001 : holdoff_evt;
               next_scnt   = stop_evt_en ? stop_evt : 24'h000000;
               next_ext_ok = 1'b0;
               next_result = 32'h00000000;
            end
         end
         arming_pkg::st_run: begin
            next_result = result + 32'h00000001;
            if (tcnt != 32'h00000000) next_tcnt = tcnt - 32'h00000001;
            if (e_fall) next_ext_ok = 1'b1;
            if (b_rise && stop_ok) begin
               next_state = arming_pkg::st_pace;
               store      = 1'b1;
               next_tcnt  = pace_cyc;
            end else if (b_rise) begin
               if (hold_evt_en && ecnt != 24'h000000) next_ecnt = ecnt - 24'h000001;
               else if (stop_evt_en && scnt != 24'h000000) next_scnt = scnt - 24'h000001;
            end
            if (!ctrl.enable) next_state = arming_pkg::st_idle;
         end
         arming_pkg::st_pace: begin
            // Held here until free-run restarts the machine or enable drops
            if (tcnt != 32'h00000000) next_tcnt = tcnt - 32'h00000001;
            else if (ctrl.free_run) next_state = arming_pkg::st_idle;
            if (!ctrl.enable) next_state = arming_pkg::st_idle;
         end
         default: next_state = arming_pkg::st_idle;
      endcase
   end

   // APB slave, zero wait states
   // Writes land at the access edge; unmapped words answer with an error and change nothing
   logic wr, rd;
   logic [31:0] status;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign status  = {22'h000000, fill[AW:0] != '0, done_flag, 4'h0, state};
   logic bad;
   always_comb begin
      bad = 1'b1;
      if (paddr == `ADDR_CTRL) bad = 1'b0;
      else if (paddr == `ADDR_HOLDOFF_TIME) bad = 1'b0;
      else if (paddr == `ADDR_HOLDOFF_EVT) bad = 1'b0;
      else if (paddr == `ADDR_START_DELAY) bad = 1'b0;
      else if (paddr == `ADDR_STOP_EVT) bad = 1'b0;
      else if (paddr == `ADDR_STATUS) bad = 1'b0;
      else if (paddr == `ADDR_RESULT) bad = 1'b0;
      else if (paddr == `ADDR_PROFILE) bad = 1'b0;
   end
   assign pslverr = psel & penable & bad;

   logic [31:0] next_prdata, prdata_q;
   logic pop, rd_setup;
   // Read data is captured in the setup cycle, so it already stands at the access edge
   assign rd_setup = psel & ~penable & ~pwrite;
   always_comb begin
      next_ctrl         = ctrl;
      next_holdoff_time = holdoff_time;
      next_holdoff_evt  = holdoff_evt;
      next_start_delay  = start_delay;
      next_stop_evt     = stop_evt;
      next_prdata       = prdata_q;
      next_done_flag    = done_flag;
      pop               = 1'b0;
      if (wr && paddr == `ADDR_CTRL) next_ctrl = arming_pkg::ctrl_t'(pwdata[11:0]);
      else if (wr && paddr == `ADDR_HOLDOFF_TIME) next_holdoff_time = pwdata;
      else if (wr && paddr == `ADDR_HOLDOFF_EVT) next_holdoff_evt = pwdata[23:0];
      else if (wr && paddr == `ADDR_START_DELAY) begin
         next_start_delay = (pwdata < MIN_DLY) ? MIN_DLY : pwdata;
      end else if (wr && paddr == `ADDR_STOP_EVT) next_stop_evt = pwdata[23:0];
      if (rd_setup && paddr == `ADDR_CTRL) next_prdata = {20'h00000, ctrl};
      else if (rd_setup && paddr == `ADDR_HOLDOFF_TIME) next_prdata = holdoff_time;
      else if (rd_setup && paddr == `ADDR_HOLDOFF_EVT) next_prdata = {8'h00, holdoff_evt};
      else if (rd_setup && paddr == `ADDR_START_DELAY) next_prdata = start_delay;
      else if (rd_setup && paddr == `ADDR_STOP_EVT) next_prdata = {8'h00, stop_evt};
      else if (rd_setup && paddr == `ADDR_STATUS) next_prdata = status;
      else if (rd_setup && paddr == `ADDR_RESULT) next_prdata = result;
      else if (rd_setup && paddr == `ADDR_PROFILE) begin
         next_prdata = (fill != '0) ? mem[rd_ptr] : 32'h00000000;
      end
      // Results are never zero, so a zero word means nothing was taken from memory
      pop = rd && paddr == `ADDR_PROFILE && prdata_q != 32'h00000000;
      // Only a done flag that the captured word showed is cleared; a new set wins
      if (rd && paddr == `ADDR_STATUS && prdata_q[8]) next_done_flag = 1'b0;
      if (store) next_done_flag = 1'b1;
   end
   assign prdata = prdata_q;

   // Profile memory; when full the newest result is dropped, older ones stay
   logic push;
   assign push = store & (fill != (AW+1)'(DEPTH));
   always_comb begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_fill   = fill + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge pclk) begin
      if (push) mem[wr_ptr] <= next_result;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl         <= arming_pkg::ctrl_t'(12'(`CTRL_RESET));
         holdoff_time <= `HOLDOFF_RESET;
         holdoff_evt  <= 24'h000000;
         start_delay  <= 32'h00000000;
         stop_evt     <= `STOP_EVT_RESET;
         prdata_q     <= 32'h00000000;
         done_flag    <= 1'b0;
         state        <= arming_pkg::st_idle;
         tcnt         <= 32'h00000000;
         dcnt         <= 32'h00000000;
         ecnt         <= 24'h000000;
         scnt         <= 24'h000000;
         ext_ok       <= 1'b0;
         result       <= 32'h00000000;
         b_prev       <= 1'b0;
         wr_ptr       <= '0;
         rd_ptr       <= '0;
         fill         <= '0;
      end else begin
         ctrl         <= next_ctrl;
         holdoff_time <= next_holdoff_time;
         holdoff_evt  <= next_holdoff_evt;
         start_delay  <= next_start_delay;
         stop_evt     <= next_stop_evt;
         prdata_q     <= next_prdata;
         done_flag    <= next_done_flag;
         state        <= next_state;
         tcnt         <= next_tcnt;
         dcnt         <= next_dcnt;
         ecnt         <= next_ecnt;
         scnt         <= next_scnt;
         ext_ok       <= next_ext_ok;
         result       <= next_result;
         b_prev       <= next_b_prev;
         wr_ptr       <= next_wr_ptr;
         rd_ptr       <= next_rd_ptr;
         fill         <= next_fill;
      end
   end
endmodule : interval_stop_arming_holdoff
`default_nettype wire

// File: shared/arming_cfg.svh
// Constants for the interval stop-arming and hold-off block.
// Assumes a 50 MHz APB clock; included by the package users.
`ifndef ARMING_CFG_SVH
`define ARMING_CFG_SVH
`define ADDR_CTRL         12'h000
`define ADDR_HOLDOFF_TIME 12'h004
`define ADDR_HOLDOFF_EVT  12'h008
`define ADDR_START_DELAY  12'h00C
`define ADDR_STOP_EVT     12'h010
`define ADDR_STATUS       12'h014
`define ADDR_RESULT       12'h018
`define ADDR_PROFILE      12'h01C
`define CLK_HZ            50000000
`define MIN_DELAY_NS      200
`define MIN_DELAY_CYC     ((`MIN_DELAY_NS * 50 + 999) / 1000)
`define PACE_FAST_HZ      7000
`define PACE_SLOW_HZ      2000
`define PACE_FAST_CYC     (`CLK_HZ / `PACE_FAST_HZ)
`define PACE_SLOW_CYC     (`CLK_HZ / `PACE_SLOW_HZ)
`define EVT_MIN           24'h000002
`define CTRL_RESET        32'h00000000
`define HOLDOFF_RESET     32'h00000000
`define STOP_EVT_RESET    24'h000001
`endif

// File: shared/arming_pkg.sv
// Types for the interval stop-arming block.
// Assumes arming_cfg.svh supplies the numeric constants.
package arming_pkg;
   typedef enum logic [3:0] {
      st_idle  = 4'b0001,
      st_armed = 4'b0010,
      st_run   = 4'b0100,
      st_pace  = 4'b1000
   } meas_state_t;
   typedef struct packed {
      logic in_a;
      logic in_b;
      logic in_c;
      logic in_e;
   } inputs_t;
   typedef struct packed {
      logic       enable;
      logic       single;
      logic       common_input_routing;
      logic       holdoff_on;
      logic       holdoff_by_events;
      logic       start_arm;
      logic       start_delay_on;
      logic       stop_arm_trailing;
      logic       use_c;
      logic       fast_model;
      logic       free_run;
      logic       arm_from_b;
   } ctrl_t;
endpackage : arming_pkg

// File: tb/arming_chk_sva.sv
// Checker for the stop-arming block; it sees only the top-level ports.
// Assumes zero-wait APB and the CTRL bit order of the ctrl_t struct.
`timescale 1ns/1ps
`default_nettype none
`include "arming_cfg.svh"
module arming_chk (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire arming_pkg::inputs_t pins,
   input wire logic                go_detect_bypass,
   input wire logic                averaging_on,
   input wire logic                meas_busy
);
   logic [11:0] ctrl;
   logic [31:0] ho_time;
   logic [31:0] run_cnt;
   logic [3:0]  e_cnt;
   logic [15:0] gap;
   wire         acc = psel && penable && pwrite;
   // Shadow copies, since the ports alone do not show the settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl    <= 12'h000;
         ho_time <= 32'h0;
         run_cnt <= 32'h0;
         e_cnt   <= 4'h0;
         gap     <= 16'hFFFF;
      end else begin
         if (acc && paddr == `ADDR_CTRL) ctrl <= pwdata[11:0];
         if (acc && paddr == `ADDR_HOLDOFF_TIME) ho_time <= pwdata;
         run_cnt <= meas_busy ? run_cnt + 32'h1 : 32'h0;
         e_cnt   <= !pins.in_e ? 4'h0 : (e_cnt == 4'hF ? e_cnt : e_cnt + 4'h1);
         // Gap only matters while free-running; otherwise parked at its ceiling
         gap     <= !ctrl[1] ? 16'hFFFF : $rose(meas_busy) ? 16'h1 :
                    (gap == 16'hFFFF ? gap : gap + 16'h1);
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   bypass_tracks_arm_a: assert property (go_detect_bypass == ctrl[6])
      else $error("bypass differs from start arming");
   avg_off_single_a: assert property (averaging_on == !ctrl[10])
      else $error("averaging differs from single mode");
   start_needs_en_a: assert property ($rose(meas_busy) |-> ctrl[11])
      else $error("measurement started while disabled");
   first_stop_a: assert property ($rose(pins.in_b) && meas_busy && $past(meas_busy)
      && ctrl[9:4] == 6'h00 |-> ##[1:6] !meas_busy) else $error("first stop not taken");
   holdoff_time_a: assert property ($fell(meas_busy) && ctrl[8] && !ctrl[7]
      |-> run_cnt >= ho_time) else $error("stop inside hold-off");
   ext_holdoff_a: assert property (ctrl[4] && e_cnt >= 4'h5 && $past(meas_busy)
      |-> meas_busy) else $error("stop before arming edge");
   pacing_gap_a: assert property ($rose(meas_busy) |->
      gap >= (ctrl[2] ? `PACE_FAST_CYC : `PACE_SLOW_CYC)) else $error("pacing too fast");
   zero_wait_a: assert property (pready) else $error("pready low");
   slverr_map_a: assert property (psel && penable |->
      pslverr == (paddr > `ADDR_PROFILE || paddr[1:0] != 2'b00))
      else $error("slave error mismatch");
   cover property ($fell(meas_busy) && ctrl[8]);
   cover property ($fell(meas_busy) && ctrl[4]);
   cover property ($rose(meas_busy) && ctrl[1]);
endmodule : arming_chk
bind interval_stop_arming_holdoff arming_chk u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
   .go_detect_bypass(go_detect_bypass), .averaging_on(averaging_on), .meas_busy(meas_busy));
`default_nettype wire

// File: tb/burst_model.sv
// Partner model: pulse burst on A, same burst half a period later on B, sync on E.
// Assumes go is a one-cycle strobe; C stays idle low, idle lines rest low.
`timescale 1ns/1ps
`default_nettype none
module burst_model (
   input  wire logic           clk,
   input  wire logic           go,
   input  wire logic [7:0]     n,
   input  wire logic [7:0]     half,
   input  wire logic [7:0]     sync_len,
   output arming_pkg::inputs_t pins
);
   int         t      = 0;
   logic       on     = 1'b0;
   logic [7:0] n_q    = 8'h01;
   logic [7:0] half_q = 8'h01;
   logic [7:0] sl_q   = 8'h00;
   // Burst shape is latched on go, so changes ahead of a burst cannot make stray pulses
   always @(posedge clk) begin
      if (go) begin
         on     <= 1'b1;
         n_q    <= n;
         half_q <= half;
         sl_q   <= sync_len;
      end
      t <= go ? 0 : t + 1;
   end
   function automatic logic pulse(input int ph);
      pulse = ph >= 0 && ph / (2 * int'(half_q)) < int'(n_q)
              && ph % (2 * int'(half_q)) < int'(half_q);
   endfunction : pulse
   always_comb begin
      pins.in_a = on && pulse(t - 2);
      pins.in_b = on && pulse(t - 2 - int'(half_q));
      pins.in_c = 1'b0;
      // Sync leads the burst, as short bursts need an external arming source
      pins.in_e = on && t < int'(sl_q);
   end
endmodule : burst_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench: APB register table, then burst measurement scenarios.
// Assumes burst_model drives the pins and the checker is bound to the DUT.
`timescale 1ns/1ps
`default_nettype none
`include "arming_cfg.svh"
module testbench;
   typedef struct { logic [11:0] a; logic [31:0] d; logic [31:0] e; } row_t;
   localparam logic [31:0] EN = 32'h800, SGL = 32'h400, COM = 32'h200, HO = 32'h100;
   localparam logic [31:0] HOEV = 32'h080, SARM = 32'h040, TRAIL = 32'h010;
   localparam logic [31:0] FAST = 32'h004, FREE = 32'h002;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
   logic        pready, pslverr, go_detect_bypass, averaging_on, meas_busy, last_err;
   logic        busy_q = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [7:0]  n = 8'h01, half = 8'h0A, sync_len = 8'h04;
   arming_pkg::inputs_t pins;
   int          mismatches = 0, n_checks = 0, rises = 0;
   row_t        rows[5];
   interval_stop_arming_holdoff DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pins(pins), .go_detect_bypass(go_detect_bypass),
      .averaging_on(averaging_on), .meas_busy(meas_busy));
   burst_model u_src (.clk(pclk), .go(go), .n(n), .half(half), .sync_len(sync_len),
      .pins(pins));
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      busy_q <= meas_busy;
      if (meas_busy && !busy_q) rises <= rises + 1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // Read data and the error flag are taken at the edge where pready is seen high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      last_err = pslverr;
      q        = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer
   task automatic wait_busy(input logic lvl);
      int i;
      for (i = 0; i < 300 && meas_busy !== lvl; i++) @(posedge pclk);
      chk({31'h0, meas_busy}, {31'h0, lvl});
   endtask : wait_busy
   task automatic meas(input logic [31:0] c, input logic [7:0] np, input logic [7:0] hp,
                       input logic [7:0] sl, input logic [31:0] exp);
      int i;
      xfer(1'b1, `ADDR_CTRL, 32'h0);
      // The disable above ends pacing at once; the poll only confirms the state has left it
      for (i = 0; i < 30; i++) begin
         xfer(1'b0, `ADDR_STATUS, 32'h0);
         if (q[3] === 1'b0) break;
         repeat (500) @(posedge pclk);
      end
      xfer(1'b1, `ADDR_CTRL, c | EN | FAST);
      n        <= np;
      half     <= hp;
      sync_len <= sl;
      go       <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      wait_busy(1'b1);
      wait_busy(1'b0);
      xfer(1'b0, `ADDR_RESULT, 32'h0);
      chk(q, exp);
      repeat (2 * hp * np + sl + 8) @(posedge pclk);
   endtask : meas
   task automatic complete_run;
      if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   initial begin
      repeat (30000) @(posedge pclk);
      mismatches++;
      complete_run;
   end
   initial begin
      rows[0] = '{`ADDR_HOLDOFF_TIME, 32'h23, 32'h23};
      rows[1] = '{`ADDR_HOLDOFF_EVT, 32'h3, 32'h3};
      rows[2] = '{`ADDR_START_DELAY, 32'h3, 32'hA};
      rows[3] = '{`ADDR_STOP_EVT, 32'hFFFFFF, 32'hFFFFFF};
      rows[4] = '{`ADDR_CTRL, 32'hFFF, 32'hFFF};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      chk({28'h0, pready, go_detect_bypass, averaging_on, meas_busy}, 32'hA);
      @(posedge pclk);
      xfer(1'b0, `ADDR_CTRL, 32'h0);
      chk(q, `CTRL_RESET);
      xfer(1'b0, `ADDR_STOP_EVT, 32'h0);
      chk(q, {8'h0, `STOP_EVT_RESET});
      foreach (rows[i]) begin
         xfer(1'b1, rows[i].a, rows[i].d);
         xfer(1'b0, rows[i].a, 32'h0);
         chk(q, rows[i].e);
      end
      xfer(1'b1, `ADDR_STOP_EVT, 32'h1);
      xfer(1'b0, 12'h020, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      xfer(1'b1, `ADDR_CTRL, SGL | SARM);
      chk({30'h0, averaging_on, go_detect_bypass}, 32'h1);
      meas(SGL, 8'd1, 8'd10, 8'd4, 32'hA);
      meas(SGL | COM | HO, 8'd3, 8'd10, 8'd4, 32'h28);
      meas(SGL | COM | HO | HOEV, 8'd4, 8'd10, 8'd4, 32'h3C);
      meas(SGL | COM | TRAIL, 8'd4, 8'd10, 8'd50, 32'h3C);
      rises = 0;
      meas(SGL | FREE, 8'd255, 8'd20, 8'd4, 32'h14);
      chk(rises, 2);
      xfer(1'b0, `ADDR_PROFILE, 32'h0);
      chk(q, 32'hA);
      complete_run;
   end
endmodule : testbench
`default_nettype wire
